// ### dso_status_out.v
// Purpose: digital status outputs of a motor drive
// Assumes: all inputs synchronous to clock_i, measurements unsigned
// Notes:   every output comes from a flip-flop
//
// Function
// RULE1: frequency flag with hysteresis on release
// RULE2: undervoltage flag while bus below threshold
// RULE3: refuse run start during undervoltage
// RULE4: undervoltage flag also held during trip
// RULE5: output-limit flag, at least 100 ms wide
// RULE6: delayed limit flag after 20 ms
// RULE7: power-fail restart flag, two cases
// RULE8: ready when prepared and no protection
// RULE9: contactor on run, off after stop
// RULE10: contactor off at once on coast/alarm
// RULE11: 100 ms pulse per stage shift
// RULE12: 100 ms pulse after seven stages
// RULE13: stage as three-bit binary code
// RULE14: stage outputs off when not patterned
// RULE15: fan status when fan control enabled
// RULE16: auto-reset flag while resetting
// RULE17: communications output from remote value only
// RULE18: heat-sink warning with 5/8 C hysteresis
// RULE19: lifetime flag on any expired part
// RULE20: reference-loss flag while input lost
// RULE21: current flag after time, 100 ms min
// RULE22: closed-loop flag on enable and run
// RULE23: all ms timing from one tick
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.vh"

module dso_status_out (
   // clock, reset, enable
   input wire clock_i,
   input wire rst_n_i,
   input wire ce_i,
   // frequency detection
   input wire [15:0] out_freq_i,
   input wire [15:0] freq_detect_level_i,
   input wire [15:0] freq_detect_hyst_i,
   // bus voltage and protection
   input wire [15:0] bus_volt_i,
   input wire [15:0] uv_level_i,
   input wire uv_trip_i,
   input wire hw_ready_i,
   input wire protect_active_i,
   input wire alarm_i,
   // output limiting
   input wire torque_limit_i,
   input wire sw_current_limit_i,
   input wire hw_overcurrent_limit_sel_i,
   input wire hw_overcurrent_limit_i,
   input wire anti_regen_i,
   // power-failure restart
   input wire momentary_pf_run_i,
   input wire at_reference_i,
   // run commands
   input wire forward_run_cmd_i,
   input wire coast_cmd_i,
   input wire motor_stopped_i,
   // pattern operation
   input wire pattern_run_i,
   input wire [2:0] pattern_stage_i,
   // fan, reset, remote, life
   input wire [1:0] fan_control_enable_i,
   input wire fan_running_i,
   input wire auto_reset_busy_i,
   input wire remote_do_i,
   input wire cap_life_i,
   input wire fan_life_i,
   input wire battery_life_i,
   // temperatures in degrees C
   input wire [7:0] heatsink_temp_i,
   input wire [7:0] trip_temp_i,
   // reference loss and current
   input wire ref_loss_setting_i,
   input wire ref_lost_i,
   input wire [15:0] out_current_i,
   input wire [15:0] current_detect_level_i,
   input wire [15:0] current_detect_timer_i,
   // closed loop
   input wire closed_loop_cancel_i,
   // status outputs
   output reg freq_detected_o,
   output reg undervoltage_flag_o,
   output reg run_permit_o,
   output reg output_limit_flag_o,
   output reg output_limit_delayed_o,
   output reg power_fail_restart_o,
   output reg ready_o,
   output reg supply_contactor_ctl_o,
   output reg stage_shift_pulse_o,
   output reg pattern_cycle_done_o,
   output reg stage_bit0_o,
   output reg stage_bit1_o,
   output reg stage_bit2_o,
   output reg fan_running_o,
   output reg auto_reset_active_o,
   output reg remote_do_o,
   output reg heatsink_warning_o,
   output reg lifetime_o,
   output reg ref_loss_o,
   output reg current_detected_o,
   output reg closed_loop_active_o
);

   localparam [14:0] TICK_LAST = `DSO_TICK_LAST;
   localparam [15:0] MIN_ON = `DSO_MIN_ON_MS;
   localparam [15:0] LIM_DLY = `DSO_LIM_DLY_MS;
   localparam [8:0] HS_ON = `DSO_HS_ON_OFS;
   localparam [8:0] HS_OFF = `DSO_HS_OFF_OFS;

   reg [14:0] tick_cnt_r;
   reg tick_r;
   reg [1:0] ct_state_r;
   reg [1:0] ct_state_nxt;
   reg pf_hold_r;
   reg [2:0] stage_prev_r;
   reg pat_prev_r;
   reg shift_req_r;
   reg done_req_r;
   wire limit_any;
   wire [16:0] fdt_off;
   wire [8:0] hs_on_thr;
   wire [8:0] hs_off_thr;
   wire cur_over;
   wire lim_pulse;
   wire lim_delay;
   wire cur_qual;
   wire cur_pulse;
   wire shift_pulse;
   wire done_pulse;

   // --------------------------------------------------------------
   // millisecond tick
   // --------------------------------------------------------------
   // one shared tick keeps all widths in phase
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_r <= 15'h0000;
         tick_r <= 1'b0;
      end else if (ce_i) begin
         tick_r <= (tick_cnt_r == TICK_LAST); // see RULE23
         if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 15'h0000;
         end else begin
            tick_cnt_r <= tick_cnt_r + 15'h0001;
         end
      end
   end

   // --------------------------------------------------------------
   // combinational conditions
   // --------------------------------------------------------------
   // hardware overcurrent limit only counts when selected
   assign limit_any = torque_limit_i | sw_current_limit_i | anti_regen_i |
      (hw_overcurrent_limit_sel_i & hw_overcurrent_limit_i); // see RULE5
   // release level; a borrow into bit 16 means the flag never releases
   assign fdt_off = {1'b0, freq_detect_level_i} - {1'b0, freq_detect_hyst_i};
   assign hs_on_thr = {1'b0, trip_temp_i} - HS_ON;
   assign hs_off_thr = {1'b0, trip_temp_i} - HS_OFF;
   assign cur_over = out_current_i > current_detect_level_i;

   // --------------------------------------------------------------
   // timers
   // --------------------------------------------------------------
   dso_ms_timer #(.COUNT_MS(MIN_ON), .ONE_SHOT(1)) u_lim_min (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(limit_any), .limit_i(MIN_ON), .done_o(lim_pulse)); // see RULE5

   dso_ms_timer #(.COUNT_MS(LIM_DLY), .ONE_SHOT(0)) u_lim_dly (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(limit_any), .limit_i(LIM_DLY), .done_o(lim_delay)); // see RULE6

   dso_ms_timer #(.COUNT_MS(MIN_ON), .ONE_SHOT(0)) u_cur_dly (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(cur_over), .limit_i(current_detect_timer_i),
      .done_o(cur_qual)); // see RULE21

   dso_ms_timer #(.COUNT_MS(MIN_ON), .ONE_SHOT(1)) u_cur_min (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(cur_qual), .limit_i(MIN_ON), .done_o(cur_pulse)); // see RULE21

   dso_ms_timer #(.COUNT_MS(MIN_ON), .ONE_SHOT(1)) u_shift (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(shift_req_r), .limit_i(MIN_ON), .done_o(shift_pulse)); // see RULE11

   dso_ms_timer #(.COUNT_MS(MIN_ON), .ONE_SHOT(1)) u_done (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .tick_i(tick_r),
      .start_i(done_req_r), .limit_i(MIN_ON), .done_o(done_pulse)); // see RULE12

   // --------------------------------------------------------------
   // pattern stage edge detection
   // --------------------------------------------------------------
   // a change to a nonzero stage while running is a shift; 7 leaving is a completed cycle
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_prev_r <= 3'h0;
         pat_prev_r <= 1'b0;
         shift_req_r <= 1'b0;
         done_req_r <= 1'b0;
      end else if (ce_i) begin
         stage_prev_r <= pattern_stage_i;
         pat_prev_r <= pattern_run_i;
         shift_req_r <= pattern_run_i && pat_prev_r && pattern_stage_i != 3'h0 &&
            pattern_stage_i != stage_prev_r; // see RULE11
         done_req_r <= pat_prev_r && stage_prev_r == 3'h7 &&
            (!pattern_run_i || pattern_stage_i != 3'h7); // see RULE12
      end
   end

   // --------------------------------------------------------------
   // contactor sequence
   // --------------------------------------------------------------
   always @* begin
      ct_state_nxt = ct_state_r;
      case (ct_state_r)
         `DSO_CT_IDLE: begin
            if (forward_run_cmd_i && run_permit_o && !alarm_i && !coast_cmd_i) begin
               ct_state_nxt = `DSO_CT_RUN; // see RULE9
            end
         end
         `DSO_CT_RUN: begin
            if (!forward_run_cmd_i) begin
               ct_state_nxt = `DSO_CT_DECEL;
            end
         end
         `DSO_CT_DECEL: begin
            if (forward_run_cmd_i) begin
               ct_state_nxt = `DSO_CT_RUN;
            end else if (motor_stopped_i) begin
               ct_state_nxt = `DSO_CT_IDLE; // see RULE9
            end
         end
         default: begin
            ct_state_nxt = `DSO_CT_IDLE;
         end
      endcase
      // coast or alarm drops the contactor without deceleration
      if (coast_cmd_i || alarm_i) begin
         ct_state_nxt = `DSO_CT_IDLE; // see RULE10
      end
   end

   // --------------------------------------------------------------
   // status registers
   // --------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ct_state_r <= `DSO_CT_IDLE;
         pf_hold_r <= 1'b0;
         freq_detected_o <= 1'b0;
         undervoltage_flag_o <= 1'b0;
         run_permit_o <= 1'b0;
         output_limit_flag_o <= 1'b0;
         output_limit_delayed_o <= 1'b0;
         power_fail_restart_o <= 1'b0;
         ready_o <= 1'b0;
         supply_contactor_ctl_o <= 1'b0;
         stage_shift_pulse_o <= 1'b0;
         pattern_cycle_done_o <= 1'b0;
         stage_bit0_o <= 1'b0;
         stage_bit1_o <= 1'b0;
         stage_bit2_o <= 1'b0;
         fan_running_o <= 1'b0;
         auto_reset_active_o <= 1'b0;
         remote_do_o <= 1'b0;
         heatsink_warning_o <= 1'b0;
         lifetime_o <= 1'b0;
         ref_loss_o <= 1'b0;
         current_detected_o <= 1'b0;
         closed_loop_active_o <= 1'b0;
      end else if (ce_i) begin
         ct_state_r <= ct_state_nxt;
         supply_contactor_ctl_o <= (ct_state_nxt != `DSO_CT_IDLE); // see RULE9
         // frequency flag: set above level, release below level minus hysteresis
         if ({1'b0, out_freq_i} > {1'b0, freq_detect_level_i}) begin
            freq_detected_o <= 1'b1; // see RULE1
         end else if ({1'b0, out_freq_i} < fdt_off && !fdt_off[16]) begin
            freq_detected_o <= 1'b0; // see RULE1
         end
         // trip keeps the flag on even after the bus recovers
         undervoltage_flag_o <= (bus_volt_i < uv_level_i) || uv_trip_i; // see RULE2, RULE4
         run_permit_o <= !((bus_volt_i < uv_level_i) || uv_trip_i); // see RULE3
         output_limit_flag_o <= lim_pulse | limit_any; // see RULE5
         output_limit_delayed_o <= lim_delay; // see RULE6
         // shutdown latch held until output reaches the reference
         if (bus_volt_i < uv_level_i) begin
            pf_hold_r <= 1'b1; // see RULE7
         end else if (at_reference_i) begin
            pf_hold_r <= 1'b0;
         end
         power_fail_restart_o <= momentary_pf_run_i | pf_hold_r |
            (bus_volt_i < uv_level_i); // see RULE7
         ready_o <= hw_ready_i && !protect_active_i && !alarm_i; // see RULE8
         stage_shift_pulse_o <= shift_pulse; // see RULE11
         pattern_cycle_done_o <= done_pulse; // see RULE12
         // code 0 or not running leaves all stage bits off
         if (pattern_run_i) begin
            stage_bit0_o <= pattern_stage_i[0]; // see RULE13
            stage_bit1_o <= pattern_stage_i[1];
            stage_bit2_o <= pattern_stage_i[2];
         end else begin
            stage_bit0_o <= 1'b0; // see RULE14
            stage_bit1_o <= 1'b0;
            stage_bit2_o <= 1'b0;
         end
         fan_running_o <= (fan_control_enable_i == `DSO_FAN_CTL_ON) &&
            fan_running_i; // see RULE15
         auto_reset_active_o <= auto_reset_busy_i; // see RULE16
         remote_do_o <= remote_do_i; // see RULE17
         // warning band: on above trip-5, off at or below trip-8
         if ({1'b0, heatsink_temp_i} > hs_on_thr && !hs_on_thr[8]) begin
            heatsink_warning_o <= 1'b1; // see RULE18
         end else if ({1'b0, heatsink_temp_i} <= hs_off_thr || hs_off_thr[8]) begin
            heatsink_warning_o <= 1'b0; // see RULE18
         end
         lifetime_o <= cap_life_i | fan_life_i | battery_life_i; // see RULE19
         ref_loss_o <= ref_loss_setting_i & ref_lost_i; // see RULE20
         current_detected_o <= cur_pulse | cur_qual; // see RULE21
         // stays on across output stops while the run command holds
         closed_loop_active_o <= !closed_loop_cancel_i && forward_run_cmd_i; // see RULE22
      end
   end

endmodule
`default_nettype wire

// ### dso_defs.vh
// Purpose: constants for the drive status output logic
// Assumes: 20 MHz system clock, millisecond tick derived internally
// Notes:   definitions only
`ifndef DSO_DEFS_VH
`define DSO_DEFS_VH

// clock and tick timing
`define DSO_CLK_HZ 20000000
`define DSO_TICK_NS 1000000
`define DSO_CLK_NS 50
`define DSO_TICK_CYC (`DSO_TICK_NS / `DSO_CLK_NS)
// last count of one tick period, tick cycles minus one
`define DSO_TICK_LAST 15'h4e1f
`define DSO_TICK_W 15

// millisecond widths and delays
`define DSO_MIN_ON_MS 16'h0064
`define DSO_LIM_DLY_MS 16'h0014
`define DSO_MS_W 16

// heat-sink warning offsets in degrees C
`define DSO_HS_ON_OFS 9'h005
`define DSO_HS_OFF_OFS 9'h008

// measurement widths
`define DSO_FREQ_W 16
`define DSO_VOLT_W 16
`define DSO_CUR_W 16
`define DSO_TEMP_W 8

// fan control setting that enables fan status
`define DSO_FAN_CTL_ON 2'h1

// contactor sequence states
`define DSO_CT_IDLE 2'h0
`define DSO_CT_RUN 2'h1
`define DSO_CT_DECEL 2'h2

`endif

// ### dso_ms_timer.v
// Purpose: millisecond counter cell, used for delays and minimum widths
// Assumes: tick_i is a one-cycle pulse each millisecond
// Notes:   mode 0 counts while start_i holds, mode 1 is a retriggerable one-shot
`timescale 1ns/1ps
`default_nettype none

module dso_ms_timer #(
   parameter [15:0] COUNT_MS = 16'h0064,
   parameter ONE_SHOT = 0
) (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   input wire ce_i,
   // control
   input wire tick_i,
   input wire start_i,
   input wire [15:0] limit_i,
   // result
   output reg done_o
);

   reg [15:0] cnt_r;
   wire [15:0] lim;

   // mode 1 uses the fixed width, mode 0 the run-time limit
   assign lim = ONE_SHOT ? COUNT_MS : limit_i;

   // --------------------------------------------------------------
   // counting
   // --------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 16'h0000;
         done_o <= 1'b0;
      end else if (ce_i) begin
         if (ONE_SHOT != 0) begin
            // retrigger reloads so the pulse always lasts the full width
            if (start_i) begin
               cnt_r <= 16'h0000;
               done_o <= 1'b1;
            end else if (done_o && tick_i) begin
               if (cnt_r + 16'h0001 >= lim) begin
                  done_o <= 1'b0;
               end
               cnt_r <= cnt_r + 16'h0001;
            end
         end else begin
            // qualification: input must hold without a gap
            if (!start_i) begin
               cnt_r <= 16'h0000;
               done_o <= 1'b0;
            end else if (cnt_r >= lim) begin
               done_o <= 1'b1;
            end else if (tick_i) begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ### dso_status_chk_assertions.sv
// Purpose: assertions on the drive status outputs
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only top-level ports, bound from the bench
`timescale 1ns/1ps
`default_nettype none
module dso_status_chk (
   // clock and control
   input wire clock_i,
   input wire rst_n_i,
   input wire ce_i,
   // observed inputs
   input wire [15:0] bus_volt_i,
   input wire [15:0] uv_level_i,
   input wire uv_trip_i,
   input wire alarm_i,
   input wire coast_cmd_i,
   input wire forward_run_cmd_i,
   input wire motor_stopped_i,
   input wire torque_limit_i,
   input wire sw_current_limit_i,
   input wire hw_overcurrent_limit_sel_i,
   input wire hw_overcurrent_limit_i,
   input wire anti_regen_i,
   input wire pattern_run_i,
   input wire [2:0] pattern_stage_i,
   input wire closed_loop_cancel_i,
   // observed outputs
   input wire undervoltage_flag_o,
   input wire supply_contactor_ctl_o,
   input wire output_limit_flag_o,
   input wire output_limit_delayed_o,
   input wire stage_bit0_o,
   input wire stage_bit1_o,
   input wire stage_bit2_o,
   input wire closed_loop_active_o
);
   // ------------------------------
   // helpers and sequences
   // ------------------------------
   // unselected hardware limit must not count as limiting
   wire lim = torque_limit_i | sw_current_limit_i | anti_regen_i
      | (hw_overcurrent_limit_sel_i & hw_overcurrent_limit_i);
   wire uvx = (bus_volt_i < uv_level_i) | uv_trip_i;
   wire [2:0] stg = {stage_bit2_o, stage_bit1_o, stage_bit0_o};
   wire ct = supply_contactor_ctl_o;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // decelerating: command gone, motor still turning
   sequence s_decel;
      ce_i && ct && !forward_run_cmd_i && !motor_stopped_i && !coast_cmd_i && !alarm_i;
   endsequence
   // stop command held a cycle, then motor stopped
   sequence s_stop;
      ce_i && ct && !forward_run_cmd_i ##1 ce_i && !forward_run_cmd_i && motor_stopped_i;
   endsequence
   a_uv_flag: assert property (ce_i && uvx |=> undervoltage_flag_o)
      else $error("undervoltage flag missing");
   a_uv_clear: assert property (ce_i && !uvx |=> !undervoltage_flag_o)
      else $error("undervoltage flag stuck");
   a_uv_refuse: assert property (ce_i && undervoltage_flag_o && !ct |=> !ct)
      else $error("contactor set during undervoltage");
   a_run_sets: assert property (ce_i && forward_run_cmd_i && !uvx
      && !undervoltage_flag_o && !coast_cmd_i && !alarm_i |=> ct)
      else $error("contactor not set on run");
   a_decel_hold: assert property (s_decel |=> ct)
      else $error("contactor dropped during deceleration");
   a_stop_drop: assert property (s_stop |=> !ct)
      else $error("contactor held after stop");
   a_coast_drop: assert property (ce_i && (coast_cmd_i || alarm_i) |=> !ct)
      else $error("contactor held on coast or alarm");
   a_limit_on: assert property (ce_i && lim |=> output_limit_flag_o)
      else $error("limit flag missing");
   a_limit_dly: assert property ($rose(output_limit_delayed_o) |->
      $past(lim, 2) && $past(lim, 3))
      else $error("delayed limit flag without limiting");
   a_stage_code: assert property (ce_i && pattern_run_i |=>
      stg == $past(pattern_stage_i))
      else $error("stage code wrong");
   a_stage_idle: assert property (ce_i && !pattern_run_i |=> stg == 3'h0)
      else $error("stage code not idle");
   a_loop_on: assert property (ce_i |=> closed_loop_active_o ==
      $past(forward_run_cmd_i && !closed_loop_cancel_i))
      else $error("closed loop flag wrong");
endmodule
`default_nettype wire

// ### dso_remote_peer.sv
// Purpose: remote master that writes the communications output value
// Assumes: bench requests a write with wr_i
// Notes:   line holds the last written value, as a link register does
`timescale 1ns/1ps
`default_nettype none
module dso_remote_peer (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // write request
   input wire logic wr_i,
   input wire logic data_i,
   // line to the drive
   output logic do_o
);
   // value changes only on a write, never from drive state
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         do_o <= 1'b0;
      end else if (wr_i) begin
         do_o <= data_i;
      end
   end
endmodule
`default_nettype wire

// ### dso_status_out_bench.sv
// Purpose: self-checking bench for the drive status outputs
// Assumes: 20 MHz clock, fixed 1 ms tick inside the design
// Notes:   100 ms widths too long to run out, only their start is seen
`timescale 1ns/1ps
`default_nettype none
module dso_status_out_bench;
   logic clock_i = '0, rst_n_i = '0, ce_i = 1'b1, uv_trip_i = '0, hw_ready_i = '0;
   logic protect_active_i = '0, alarm_i = '0, torque_limit_i = '0, sw_current_limit_i = '0;
   logic hw_overcurrent_limit_sel_i = '0, hw_overcurrent_limit_i = '0, anti_regen_i = '0;
   logic momentary_pf_run_i = '0, at_reference_i = '0, forward_run_cmd_i = '0;
   logic coast_cmd_i = '0, motor_stopped_i = '0, pattern_run_i = '0, fan_running_i = '0;
   logic auto_reset_busy_i = '0, cap_life_i = '0, fan_life_i = '0, battery_life_i = '0;
   logic ref_loss_setting_i = '0, ref_lost_i = '0, closed_loop_cancel_i = '0, wr = '0;
   logic wdat = '0, fq = '0, hs = '0, uvx;
   logic [15:0] out_freq_i = '0, freq_detect_level_i = 16'h03e8, freq_detect_hyst_i = 16'h0032;
   logic [15:0] bus_volt_i = 16'h0258, uv_level_i = 16'h01f4, out_current_i = '0;
   logic [15:0] current_detect_level_i = 16'h0064, current_detect_timer_i = 16'h0002;
   logic [7:0] heatsink_temp_i = 8'h1e, trip_temp_i = 8'h5a;
   logic [2:0] pattern_stage_i = '0;
   logic [1:0] fan_control_enable_i = '0;
   logic [31:0] rnd;
   logic [13:0] q[$];
   logic [13:0] e;
   integer seed = 32'h7b37, fails = 0, n_tests = 0, cyc = 0, k;
   wire remote_do_i, freq_detected_o, undervoltage_flag_o, run_permit_o, output_limit_flag_o;
   wire output_limit_delayed_o, power_fail_restart_o, ready_o, supply_contactor_ctl_o;
   wire stage_shift_pulse_o, pattern_cycle_done_o, stage_bit0_o, stage_bit1_o, stage_bit2_o;
   wire fan_running_o, auto_reset_active_o, remote_do_o, heatsink_warning_o, lifetime_o;
   wire ref_loss_o, current_detected_o, closed_loop_active_o;
   dso_status_out uut (.*);
   dso_remote_peer peer (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr_i(wr), .data_i(wdat),
      .do_o(remote_do_i));
   // ------------------------------
   // clock, guard, report
   // ------------------------------
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   // hang guard, run needs about 43k cycles
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails++;
         results;
      end
   end
   task results;
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task cmp_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t flag %b not %b", $time, got, exp);
      end
   endtask
   task cmp_vec(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t levels %b not %b", $time, got, exp);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task fall;
      @(negedge clock_i);
   endtask
   // monitor: oldest note checked once the edge after it has landed
   always @(posedge clock_i) begin
      #1;
      if (q.size() > 0) begin
         e = q.pop_front();
         cmp_vec({freq_detected_o, undervoltage_flag_o, closed_loop_active_o, fan_running_o,
            lifetime_o, heatsink_warning_o, ref_loss_o, remote_do_o, auto_reset_active_o,
            stage_bit2_o, stage_bit1_o, stage_bit0_o}, e[11:0]);
         if (e[13]) cmp_bit(ready_o, e[12]);
      end
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      step(2);
      fall;
      rst_n_i = 1'b1;
      step(2);
      // limiting: unselected hardware limit is ignored, width outlasts cause
      fall;
      hw_overcurrent_limit_i = 1'b1;
      step(50);
      cmp_bit(output_limit_flag_o, 1'b0);
      fall;
      hw_overcurrent_limit_sel_i = 1'b1;
      step(2);
      cmp_bit(output_limit_flag_o, 1'b1);
      fall;
      {hw_overcurrent_limit_sel_i, hw_overcurrent_limit_i, torque_limit_i} = 3'b001;
      step(1000);
      cmp_bit(output_limit_delayed_o, 1'b0);
      fall;
      torque_limit_i = 1'b0;
      step(1000);
      cmp_bit(output_limit_flag_o, 1'b1);
      // pattern: walk stages 1..7, then leave the last one
      fall;
      pattern_run_i = 1'b1;
      for (k = 1; k < 8; k++) begin
         fall;
         pattern_stage_i = k[2:0];
         step(5);
      end
      cmp_bit(stage_shift_pulse_o, 1'b1);
      cmp_bit(pattern_cycle_done_o, 1'b0);
      fall;
      pattern_stage_i = 3'h1;
      step(5);
      cmp_bit(pattern_cycle_done_o, 1'b1);
      step(1000);
      cmp_bit(pattern_cycle_done_o, 1'b1);
      // contactor: run, decelerate, stop, then coast and alarm cut it
      fall;
      {pattern_run_i, forward_run_cmd_i} = 2'b01;
      step(2);
      cmp_bit(supply_contactor_ctl_o, 1'b1);
      fall;
      forward_run_cmd_i = 1'b0;
      step(20);
      cmp_bit(supply_contactor_ctl_o, 1'b1);
      fall;
      motor_stopped_i = 1'b1;
      step(2);
      cmp_bit(supply_contactor_ctl_o, 1'b0);
      for (k = 0; k < 2; k++) begin
         fall;
         {coast_cmd_i, alarm_i, forward_run_cmd_i, motor_stopped_i} = 4'b0010;
         step(2);
         cmp_bit(supply_contactor_ctl_o, 1'b1);
         fall;
         {coast_cmd_i, alarm_i} = k[0] ? 2'b01 : 2'b10;
         step(2);
         cmp_bit(supply_contactor_ctl_o, 1'b0);
      end
      // undervoltage one below the level refuses a run, level itself clears
      fall;
      {coast_cmd_i, alarm_i, forward_run_cmd_i, motor_stopped_i} = 4'b0001;
      bus_volt_i = 16'h01f3;
      step(3);
      fall;
      forward_run_cmd_i = 1'b1;
      step(5);
      cmp_bit(supply_contactor_ctl_o, 1'b0);
      cmp_bit(run_permit_o, 1'b0);
      cmp_bit(power_fail_restart_o, 1'b1);
      fall;
      {forward_run_cmd_i, bus_volt_i} = {1'b0, 16'h01f4};
      step(3);
      cmp_bit(undervoltage_flag_o, 1'b0);
      cmp_bit(power_fail_restart_o, 1'b1);
      fall;
      at_reference_i = 1'b1;
      step(3);
      cmp_bit(power_fail_restart_o, 1'b0);
      // current: two ms ticks above the level before the flag
      fall;
      out_current_i = 16'h00c8;
      step(100);
      cmp_bit(current_detected_o, 1'b0);
      for (k = 0; k < 60000 && current_detected_o !== 1'b1; k++) step(1);
      cmp_bit(current_detected_o, 1'b1);
      cmp_bit(k >= 19000, 1'b1);
      fall;
      out_current_i = '0;
      step(1000);
      cmp_bit(current_detected_o, 1'b1);
      // random phase: each level output predicted from its own rule
      for (k = 0; k < 2000; k++) begin
         fall;
         rnd = $random(seed);
         out_freq_i = 16'h03b6 + {9'h000, rnd[6:0]};
         bus_volt_i = 16'h01ee + {12'h000, rnd[10:7]};
         heatsink_temp_i = 8'h4e + {4'h0, rnd[14:11]};
         rnd = $random(seed);
         {uv_trip_i, hw_ready_i, protect_active_i, forward_run_cmd_i, pattern_run_i,
            pattern_stage_i, fan_control_enable_i, fan_running_i, auto_reset_busy_i,
            cap_life_i, fan_life_i, battery_life_i, ref_loss_setting_i, ref_lost_i,
            closed_loop_cancel_i, wr, wdat, torque_limit_i, sw_current_limit_i,
            hw_overcurrent_limit_sel_i, hw_overcurrent_limit_i, anti_regen_i} = rnd[24:0];
         if (out_freq_i > freq_detect_level_i) fq = 1'b1;
         else if (out_freq_i + freq_detect_hyst_i < freq_detect_level_i) fq = 1'b0;
         if (heatsink_temp_i + 8'h05 > trip_temp_i) hs = 1'b1;
         else if (heatsink_temp_i + 8'h08 <= trip_temp_i) hs = 1'b0;
         uvx = (bus_volt_i < uv_level_i) | uv_trip_i;
         q.push_back({~uvx, hw_ready_i & ~protect_active_i, fq, uvx,
            forward_run_cmd_i & ~closed_loop_cancel_i,
            (fan_control_enable_i == 2'h1) & fan_running_i,
            cap_life_i | fan_life_i | battery_life_i, hs, ref_loss_setting_i & ref_lost_i,
            remote_do_i, auto_reset_busy_i, pattern_run_i ? pattern_stage_i : 3'h0});
      end
      step(3);
      results;
   end
endmodule
bind dso_status_out dso_status_chk chk (.*);
`default_nettype wire
